// ==== rtl/csf_pkg.sv ====
// Package with register map, field positions and reset values of the codec status bank
package csf_pkg;
    localparam logic [7:0] CSF_ADDR_BUS_COND  = 8'h22;
    localparam logic [7:0] CSF_ADDR_RSVD_A    = 8'h23;
    localparam logic [7:0] CSF_ADDR_ADC_FLAGS = 8'h24;
    localparam logic [7:0] CSF_ADDR_PWR_STAT  = 8'h25;
    localparam logic [7:0] CSF_ADDR_DAC_GAIN  = 8'h26;
    localparam logic [7:0] CSF_ADDR_OVFL      = 8'h27;
    localparam logic [7:0] CSF_ADDR_RSVD_B_LO = 8'h28;
    localparam logic [7:0] CSF_ADDR_RSVD_B_HI = 8'h2b;
    localparam logic [7:0] CSF_ADDR_PLAY_EVT  = 8'h2c;

    // Field positions
    localparam int CSF_BIT_GEN_CALL     = 5;
    localparam int CSF_BIT_ADC_GAIN_OK  = 7;
    localparam int CSF_BIT_ADC_PWR      = 6;
    localparam int CSF_BIT_AGC_SAT      = 5;
    localparam int CSF_BIT_LDAC_PWR     = 7;
    localparam int CSF_BIT_LHP_PWR      = 5;
    localparam int CSF_BIT_SPK_PWR      = 4;
    localparam int CSF_BIT_RDAC_PWR     = 3;
    localparam int CSF_BIT_RHP_PWR      = 1;
    localparam int CSF_BIT_LDAC_GAIN_OK = 4;
    localparam int CSF_BIT_RDAC_GAIN_OK = 0;
    localparam int CSF_BIT_LDAC_OVFL    = 7;
    localparam int CSF_BIT_RDAC_OVFL    = 6;
    localparam int CSF_BIT_DAC_SHF_OVFL = 5;
    localparam int CSF_BIT_ADC_OVFL     = 3;
    localparam int CSF_BIT_ADC_SHF_OVFL = 1;
    localparam int CSF_BIT_SHORT        = 7;
    localparam int CSF_BIT_BUTTON       = 5;
    localparam int CSF_BIT_HEADSET      = 4;
    localparam int CSF_BIT_LDRC         = 3;
    localparam int CSF_BIT_RDRC         = 2;

    // Number of sticky flags in the overflow and playback event registers
    localparam int CSF_N_OVFL  = 5;
    localparam int CSF_N_EVT   = 5;

    // Reset values
    localparam logic [7:0] CSF_RST_BUS_COND = 8'h00;
    localparam logic [7:0] CSF_RST_ZERO     = 8'h00;
    // Undefined reset value resolved to zero
    localparam logic       CSF_RST_UNDEF    = 1'b0;
endpackage

// ==== rtl/csf_regbank.sv ====
// Codec control and status register bank with sticky flags and live status
//
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps
`default_nettype none

module csf_regbank
    import csf_pkg::*;
(
    input  wire logic       CORE_CLK_I,
    input  wire logic       RST_I,
    input  wire logic [7:0] ADDR_I,
    input  wire logic [7:0] WDATA_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    output logic      [7:0] RDATA_O,
    output logic            GEN_CALL_EN_O,
    input  wire logic       ADC_GAIN_OK_I,
    input  wire logic       ADC_PWR_I,
    input  wire logic       LDAC_PWR_I,
    input  wire logic       RDAC_PWR_I,
    input  wire logic       LEFT_HEADPHONE_DRIVER_PWR_I,
    input  wire logic       RIGHT_HEADPHONE_DRIVER_PWR_I,
    input  wire logic       SPK_PWR_I,
    input  wire logic       LDAC_GAIN_OK_I,
    input  wire logic       RDAC_GAIN_OK_I,
    input  wire logic       AGC_SAT_I,
    input  wire logic       LDAC_OVFL_I,
    input  wire logic       RDAC_OVFL_I,
    input  wire logic       DAC_SHIFT_OVFL_I,
    input  wire logic       ADC_OVFL_I,
    input  wire logic       ADC_SHIFT_OVFL_I,
    input  wire logic       SHORT_DET_I,
    input  wire logic       BUTTON_DET_I,
    input  wire logic       HEADSET_DET_I,
    input  wire logic       LEFT_DYNAMIC_RANGE_COMPRESSOR_OVER_I,
    input  wire logic       RIGHT_DYNAMIC_RANGE_COMPRESSOR_OVER_I
);
    // Live status levels come from analog/other domains
    localparam int N_LIVE = 9;
    localparam int N_SRC  = 1 + CSF_N_OVFL + CSF_N_EVT;

    logic [N_LIVE-1:0] live_raw;
    logic [N_LIVE-1:0] live_s;
    logic [N_SRC-1:0]  src_raw;
    logic [N_SRC-1:0]  src_s;
    logic [N_SRC-1:0]  src_d_ff;
    logic [N_SRC-1:0]  src_rise;
    logic              gen_call_ff;
    logic [7:0]        rdata_ff;
    logic [7:0]        nxt_rdata;
    logic              rd_adc;
    logic              rd_ovfl;
    logic              rd_evt;
    logic              agc_flag;
    logic [CSF_N_OVFL-1:0] ovfl_flag;
    logic [CSF_N_EVT-1:0]  evt_flag;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
        hit = (a == r);
    endfunction

    assign live_raw = {ADC_GAIN_OK_I, ADC_PWR_I, LDAC_PWR_I, RDAC_PWR_I,
                       LEFT_HEADPHONE_DRIVER_PWR_I, RIGHT_HEADPHONE_DRIVER_PWR_I,
                       SPK_PWR_I, LDAC_GAIN_OK_I, RDAC_GAIN_OK_I};

    assign src_raw = {AGC_SAT_I,
                      LDAC_OVFL_I, RDAC_OVFL_I, DAC_SHIFT_OVFL_I, ADC_OVFL_I, ADC_SHIFT_OVFL_I,
                      SHORT_DET_I, BUTTON_DET_I, HEADSET_DET_I,
                      LEFT_DYNAMIC_RANGE_COMPRESSOR_OVER_I, RIGHT_DYNAMIC_RANGE_COMPRESSOR_OVER_I};

    csf_sync2 #(.W(N_LIVE)) u_sync_live (
        .clk_i (CORE_CLK_I),
        .rst_i (RST_I),
        .d_i   (live_raw),
        .q_o   (live_s)
    );

    csf_sync2 #(.W(N_SRC)) u_sync_src (
        .clk_i (CORE_CLK_I),
        .rst_i (RST_I),
        .d_i   (src_raw),
        .q_o   (src_s)
    );

    // Edge detect so a level still high after a read does not re-set the flag
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            src_d_ff <= '0;
        end else begin
            src_d_ff <= src_s;
        end
    end

    assign src_rise = src_s & ~src_d_ff;

    assign rd_adc  = RD_I && hit(ADDR_I, CSF_ADDR_ADC_FLAGS);
    assign rd_ovfl = RD_I && hit(ADDR_I, CSF_ADDR_OVFL);
    assign rd_evt  = RD_I && hit(ADDR_I, CSF_ADDR_PLAY_EVT);

    csf_sticky #(.W(1)) u_agc (
        .clk_i  (CORE_CLK_I),
        .rst_i  (RST_I),
        .set_i  (src_rise[N_SRC-1]),
        .clr_i  (rd_adc),
        .flag_o (agc_flag)
    );

    csf_sticky #(.W(CSF_N_OVFL)) u_ovfl (
        .clk_i  (CORE_CLK_I),
        .rst_i  (RST_I),
        .set_i  (src_rise[CSF_N_EVT +: CSF_N_OVFL]),
        .clr_i  (rd_ovfl),
        .flag_o (ovfl_flag)
    );

    csf_sticky #(.W(CSF_N_EVT)) u_evt (
        .clk_i  (CORE_CLK_I),
        .rst_i  (RST_I),
        .set_i  (src_rise[CSF_N_EVT-1:0]),
        .clr_i  (rd_evt),
        .flag_o (evt_flag)
    );

    // Control register; reserved bits are not stored and read back zero
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            gen_call_ff <= CSF_RST_BUS_COND[CSF_BIT_GEN_CALL];
        end else if (WR_I && hit(ADDR_I, CSF_ADDR_BUS_COND)) begin
            gen_call_ff <= WDATA_I[CSF_BIT_GEN_CALL];
        end
    end

    // Read mux; writes to status or reserved registers are dropped
    always_comb begin
        nxt_rdata = CSF_RST_ZERO;
        case (ADDR_I)
            CSF_ADDR_BUS_COND: begin
                nxt_rdata[CSF_BIT_GEN_CALL] = gen_call_ff;
            end
            CSF_ADDR_ADC_FLAGS: begin
                nxt_rdata[CSF_BIT_ADC_GAIN_OK] = live_s[8];
                nxt_rdata[CSF_BIT_ADC_PWR]     = live_s[7];
                nxt_rdata[CSF_BIT_AGC_SAT]     = agc_flag;
            end
            CSF_ADDR_PWR_STAT: begin
                nxt_rdata[CSF_BIT_LDAC_PWR] = live_s[6];
                nxt_rdata[CSF_BIT_RDAC_PWR] = live_s[5];
                nxt_rdata[CSF_BIT_LHP_PWR]  = live_s[4];
                nxt_rdata[CSF_BIT_RHP_PWR]  = live_s[3];
                nxt_rdata[CSF_BIT_SPK_PWR]  = live_s[2];
            end
            CSF_ADDR_DAC_GAIN: begin
                nxt_rdata[CSF_BIT_LDAC_GAIN_OK] = live_s[1];
                nxt_rdata[CSF_BIT_RDAC_GAIN_OK] = live_s[0];
            end
            CSF_ADDR_OVFL: begin
                nxt_rdata[CSF_BIT_LDAC_OVFL]    = ovfl_flag[4];
                nxt_rdata[CSF_BIT_RDAC_OVFL]    = ovfl_flag[3];
                nxt_rdata[CSF_BIT_DAC_SHF_OVFL] = ovfl_flag[2];
                nxt_rdata[CSF_BIT_ADC_OVFL]     = ovfl_flag[1];
                nxt_rdata[CSF_BIT_ADC_SHF_OVFL] = ovfl_flag[0];
            end
            CSF_ADDR_PLAY_EVT: begin
                nxt_rdata[CSF_BIT_SHORT]   = evt_flag[4];
                nxt_rdata[CSF_BIT_BUTTON]  = evt_flag[3];
                nxt_rdata[CSF_BIT_HEADSET] = evt_flag[2];
                nxt_rdata[CSF_BIT_LDRC]    = evt_flag[1];
                nxt_rdata[CSF_BIT_RDRC]    = evt_flag[0];
            end
            default: begin
                nxt_rdata = CSF_RST_ZERO;
            end
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            rdata_ff <= CSF_RST_ZERO;
        end else if (RD_I) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= CSF_RST_ZERO;
        end
    end

    assign RDATA_O       = rdata_ff;
    assign GEN_CALL_EN_O = gen_call_ff;
endmodule
`default_nettype wire

// ==== rtl/csf_sticky.sv ====
// Vector of sticky flags, set by event, cleared by a read; set wins
`timescale 1ns/1ps
`default_nettype none
module csf_sticky #(
    parameter int W = 4
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] set_i,
    input  wire logic         clr_i,
    output logic      [W-1:0] flag_o
);
    logic [W-1:0] flag_ff;

    generate
        for (genvar g = 0; g < W; g++) begin : g_flag
            always_ff @(posedge clk_i or posedge rst_i) begin
                if (rst_i) begin
                    flag_ff[g] <= 1'b0;
                end else if (set_i[g]) begin
                    flag_ff[g] <= 1'b1;
                end else if (clr_i) begin
                    flag_ff[g] <= 1'b0;
                end
            end
        end
    endgenerate

    assign flag_o = flag_ff;
endmodule
`default_nettype wire

// ==== rtl/csf_sync2.sv ====
// Two-flop synchroniser vector for live status and event source inputs
`timescale 1ns/1ps
`default_nettype none
module csf_sync2 #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= d_i;
            sync_ff <= meta_ff;
        end
    end

    assign q_o = sync_ff;
endmodule
`default_nettype wire

// ==== verification/csf_regbank_checker.sv ====
// Assertion checker for the codec status register bank
`timescale 1ns/1ps
`default_nettype none
module csf_regbank_checker
    import csf_pkg::*;
(
    input wire logic       CORE_CLK_I, RST_I, WR_I, RD_I, GEN_CALL_EN_O,
    input wire logic [7:0] ADDR_I, WDATA_I, RDATA_O,
    input wire logic       ADC_GAIN_OK_I, ADC_PWR_I, LDAC_PWR_I, RDAC_PWR_I, SPK_PWR_I,
    input wire logic       LEFT_HEADPHONE_DRIVER_PWR_I, RIGHT_HEADPHONE_DRIVER_PWR_I,
    input wire logic       LDAC_GAIN_OK_I, RDAC_GAIN_OK_I, LDAC_OVFL_I, SHORT_DET_I
);
    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RST_I);
    logic [7:0] pwr_v;
    logic [1:0] adc_v;
    logic [1:0] gain_v;
    logic [1:0] up_ff;
    assign pwr_v = {LDAC_PWR_I, 1'b0, LEFT_HEADPHONE_DRIVER_PWR_I, SPK_PWR_I, RDAC_PWR_I, 1'b0,
                    RIGHT_HEADPHONE_DRIVER_PWR_I, 1'b0};
    assign adc_v = {ADC_GAIN_OK_I, ADC_PWR_I};
    assign gain_v = {LDAC_GAIN_OK_I, RDAC_GAIN_OK_I};
    // Synchronisers restart at reset, so live checks wait for them to refill
    always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
        if (RST_I) up_ff <= 2'd0;
        else if (up_ff != 2'd3) up_ff <= up_ff + 2'd1;
    end
    sequence s_steady(v); $stable(v)[*3]; endsequence
    sequence s_quiet; (!RD_I)[*5]; endsequence
    property p_rdata_idle; !RD_I |=> RDATA_O == 8'h00; endproperty
    property p_gc_write; WR_I && ADDR_I == CSF_ADDR_BUS_COND |=> GEN_CALL_EN_O == $past(WDATA_I[5]); endproperty
    property p_gc_hold; !(WR_I && ADDR_I == CSF_ADDR_BUS_COND) |=> $stable(GEN_CALL_EN_O); endproperty
    property p_gc_read; RD_I && ADDR_I == CSF_ADDR_BUS_COND |=> RDATA_O == {2'b00, GEN_CALL_EN_O, 5'h00};
    endproperty
    property p_pwr; s_steady(pwr_v) ##0 (up_ff == 2'd3 && RD_I && ADDR_I == CSF_ADDR_PWR_STAT)
        |=> (RDATA_O & 8'hba) == $past(pwr_v); endproperty
    property p_adc; s_steady(adc_v) ##0 (up_ff == 2'd3 && RD_I && ADDR_I == CSF_ADDR_ADC_FLAGS)
        |=> RDATA_O[7:6] == $past(adc_v); endproperty
    property p_gain; s_steady(gain_v) ##0 (up_ff == 2'd3 && RD_I && ADDR_I == CSF_ADDR_DAC_GAIN)
        |=> {RDATA_O[4], RDATA_O[0]} == $past(gain_v); endproperty
    property p_ovf_set; (up_ff == 2'd3 && $rose(LDAC_OVFL_I)) ##1 s_quiet ##1 (RD_I && ADDR_I == CSF_ADDR_OVFL)
        |=> RDATA_O[7]; endproperty
    property p_evt_set; (up_ff == 2'd3 && $rose(SHORT_DET_I)) ##1 s_quiet ##1 (RD_I && ADDR_I == CSF_ADDR_PLAY_EVT)
        |=> RDATA_O[7]; endproperty
    property p_clear; (!LDAC_OVFL_I)[*6] ##0 (RD_I && ADDR_I == CSF_ADDR_OVFL) ##1 (!LDAC_OVFL_I && !RD_I)
        ##1 (!LDAC_OVFL_I && RD_I && ADDR_I == CSF_ADDR_OVFL) |=> !RDATA_O[7]; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero outside a read");
    a_gc_write: assert property (p_gc_write) else $error("general call enable not written");
    a_gc_hold: assert property (p_gc_hold) else $error("general call enable moved");
    a_gc_read: assert property (p_gc_read) else $error("bus condition readback wrong");
    a_pwr: assert property (p_pwr) else $error("power status wrong");
    a_adc: assert property (p_adc) else $error("adc status wrong");
    a_gain: assert property (p_gain) else $error("dac gain status wrong");
    a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");
    a_evt_set: assert property (p_evt_set) else $error("short flag not set");
    a_clear: assert property (p_clear) else $error("overflow flag not cleared by read");
endmodule
bind csf_regbank csf_regbank_checker i_csf_regbank_checker (
    .CORE_CLK_I(CORE_CLK_I), .RST_I(RST_I), .WR_I(WR_I), .RD_I(RD_I), .GEN_CALL_EN_O(GEN_CALL_EN_O),
    .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .RDATA_O(RDATA_O), .ADC_GAIN_OK_I(ADC_GAIN_OK_I),
    .ADC_PWR_I(ADC_PWR_I), .LDAC_PWR_I(LDAC_PWR_I), .RDAC_PWR_I(RDAC_PWR_I), .SPK_PWR_I(SPK_PWR_I),
    .LEFT_HEADPHONE_DRIVER_PWR_I(LEFT_HEADPHONE_DRIVER_PWR_I),
    .RIGHT_HEADPHONE_DRIVER_PWR_I(RIGHT_HEADPHONE_DRIVER_PWR_I),
    .LDAC_GAIN_OK_I(LDAC_GAIN_OK_I), .RDAC_GAIN_OK_I(RDAC_GAIN_OK_I), .LDAC_OVFL_I(LDAC_OVFL_I),
    .SHORT_DET_I(SHORT_DET_I));
`default_nettype wire

// ==== verification/csf_regbank_tb.sv ====
// Self-checking testbench for the codec status register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; \
    $display("unexpected %s expected %h seen %h", n, e, g); end end
module csf_regbank_tb
    import csf_pkg::*;
;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic       gc_en;
    logic [8:0] st = '0;
    logic [10:0] ev = '0;
    int         fails = 0;
    int         check_count = 0;
    logic [7:0] st_a [9] = '{8'h24, 8'h24, 8'h25, 8'h25, 8'h25, 8'h25, 8'h25, 8'h26, 8'h26};
    int         st_b [9] = '{7, 6, 7, 3, 5, 1, 4, 4, 0};
    logic [7:0] ev_a [11] = '{8'h24, 8'h27, 8'h27, 8'h27, 8'h27, 8'h27, 8'h2c, 8'h2c, 8'h2c, 8'h2c, 8'h2c};
    int         ev_b [11] = '{5, 7, 6, 5, 3, 1, 7, 5, 4, 3, 2};
    always #4 clk = ~clk;
    csf_regbank i_csf_regbank (
        .CORE_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .GEN_CALL_EN_O(gc_en), .ADC_GAIN_OK_I(st[0]), .ADC_PWR_I(st[1]),
        .LDAC_PWR_I(st[2]), .RDAC_PWR_I(st[3]), .LEFT_HEADPHONE_DRIVER_PWR_I(st[4]),
        .RIGHT_HEADPHONE_DRIVER_PWR_I(st[5]), .SPK_PWR_I(st[6]), .LDAC_GAIN_OK_I(st[7]),
        .RDAC_GAIN_OK_I(st[8]), .AGC_SAT_I(ev[0]), .LDAC_OVFL_I(ev[1]), .RDAC_OVFL_I(ev[2]),
        .DAC_SHIFT_OVFL_I(ev[3]), .ADC_OVFL_I(ev[4]), .ADC_SHIFT_OVFL_I(ev[5]), .SHORT_DET_I(ev[6]),
        .BUTTON_DET_I(ev[7]), .HEADSET_DET_I(ev[8]), .LEFT_DYNAMIC_RANGE_COMPRESSOR_OVER_I(ev[9]),
        .RIGHT_DYNAMIC_RANGE_COMPRESSOR_OVER_I(ev[10]));
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] q);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        q = rdata;
    endtask
    task automatic t_reset_map();
        logic [7:0] q;
        logic [7:0] map [10] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h2b, 8'h2c, 8'h40};
        `CHK("general call enable", 1'b0, gc_en)
        for (int i = 0; i < 10; i++) begin
            rd_reg(map[i], q);
            `CHK("reset value", 8'h00, q)
        end
    endtask
    task automatic t_gen_call();
        logic [7:0] q;
        wr_reg(CSF_ADDR_BUS_COND, 8'h20);
        `CHK("general call enable", 1'b1, gc_en)
        // Reserved slot takes zeros only; the dac gain register is never written
        wr_reg(CSF_ADDR_RSVD_A, 8'h00);
        `CHK("general call kept", 1'b1, gc_en)
        rd_reg(CSF_ADDR_BUS_COND, q);
        `CHK("bus condition", 8'h20, q)
        wr_reg(CSF_ADDR_BUS_COND, 8'h00);
        `CHK("general call disable", 1'b0, gc_en)
    endtask
    task automatic t_live();
        logic [7:0] q;
        for (int i = 0; i < 9; i++) begin
            @(posedge clk);
            st <= 9'h001 << i;
            repeat (4) @(posedge clk);
            rd_reg(st_a[i], q);
            `CHK("live status", 8'h01 << st_b[i], q)
        end
        @(posedge clk);
        st <= '0;
        repeat (4) @(posedge clk);
        rd_reg(CSF_ADDR_DAC_GAIN, q);
        `CHK("live status low", 8'h00, q)
    endtask
    task automatic t_sticky();
        logic [7:0] q;
        for (int i = 0; i < 11; i++) begin
            @(posedge clk);
            ev <= 11'h001 << i;
            repeat (5) @(posedge clk);
            rd_reg(ev_a[i], q);
            `CHK("flag set", 8'h01 << ev_b[i], q)
            // Source still high: a held level must not set the flag again
            rd_reg(ev_a[i], q);
            `CHK("flag cleared", 8'h00, q)
            @(posedge clk);
            ev <= '0;
            repeat (5) @(posedge clk);
        end
    endtask
    task automatic t_set_wins();
        logic [7:0] q1;
        logic [7:0] q2;
        // Sweep the event against the read so one case lands on the clearing edge
        for (int d = 0; d < 6; d++) begin
            @(posedge clk);
            ev[1] <= 1'b1;
            repeat (d) @(posedge clk);
            rd_reg(CSF_ADDR_OVFL, q1);
            rd_reg(CSF_ADDR_OVFL, q2);
            `CHK("event not lost", 1'b1, q1[7] | q2[7])
            @(posedge clk);
            ev[1] <= 1'b0;
            repeat (8) @(posedge clk);
            rd_reg(CSF_ADDR_OVFL, q1);
            rd_reg(CSF_ADDR_OVFL, q2);
            `CHK("overflow idle", 8'h00, q2)
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        t_reset_map();
        t_gen_call();
        t_live();
        t_sticky();
        t_set_wins();
        give_verdict();
    end
    // The full run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        give_verdict();
    end
endmodule
`default_nettype wire
